// >>> hw/btm_test_ctrl.sv
// Board test mode control: master test register, input readback and output forcing.
// Assumes bus strobes, chip select and pins are synchronous to clk_sys; the
// microprocessor cycle is a single-cycle write_strobe_n or read_strobe_n low.
// How it works
// RULE1: Writes to unused test register bits change nothing.
// RULE2: Host writes zeros to unused bits and masks them on read.
// RULE3: Writable test bits have no reset value unless stated.
// RULE4: Master bits except factory, analog, bypass clear on hardware or master reset.
// RULE5: Factory and bypass clear on chip select high; analog also needs reset.
// RULE6: Pins float bit tri-states all outputs except data bus.
// RULE7: Bus float bit tri-states the data bus too.
// RULE8: Pin test bit puts sub-blocks in test mode; writes force outputs.
// RULE9: Bus drive by select with pin test: select high drives bus, overrides float.
// RULE10: Factory test bit makes test access port; ORed with pin test.
// RULE11: Bypass holds clock units in reset and feeds serial input directly.
// RULE12: Host enters test mode zero by writing zero to listed addresses.
// RULE13: In test mode, reads at 82H to 84H return live input levels.
// RULE14: Clocks, serial pair, buses, strobes and reset are not readable; code reads tx_fifo_clk at 83H and rx_fifo_clk at 84H.
// RULE15: Writes to 90H, 96H, E0H, FORCE_GENERAL_PINS force the listed outputs.
// RULE16: D0H and D2H force receive pins, applied on receive FIFO clock rise; code passes rx_cell_pulse and rx_flow_field_out through at once.
// RULE17: Forced interrupt one drives open-drain pin low; zero releases it.
// RULE18: Host waits two byte clocks for forced receive frame pulse.
// RULE19: Host sets transmit frame pulse direction before reading or forcing it.
// RULE20: Serial transmit, line clocks, data bus, cell available not forceable; code forces rx_cell_avail via D0H.
// RULE21: Address bit seven high selects the test register space.
// RULE22: Forced values hold until rewritten or test mode is left.
`timescale 1ns/10ps
module btm_test_ctrl (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hw_reset_n,
	input wire logic master_reset,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire btm_pkg::btm_pins_in_t pins_in,
	input wire logic internal_byte_clk,
	input wire btm_pkg::btm_force_t normal_out,
	input wire logic normal_irq,
	input wire logic tx_frame_dir_sel,
	output btm_pkg::btm_force_t pins_out,
	output btm_pkg::btm_force_t pins_oe,
	output logic irq_pin_n_o,
	output logic irq_pin_n_oe,
	output btm_pkg::btm_mode_t mode,
	output logic sub_block_test,
	output logic clk_units_reset,
	output logic serial_bypass
);
	import btm_pkg::*;

	logic [6:0] master;
	btm_force_t forced;
	btm_force_t rx_staged;
	logic force_irq;
	logic [RFP_STAGES-1:0] rfp_pipe;
	logic rx_fifo_clk_q;
	logic internal_byte_clk_q;
	logic test_mode;
	logic wr;
	logic rd;
	logic [7:0] next_rdata;
	btm_force_t next_out;
	btm_force_t next_oe;
	logic next_data_oe;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	assign wr = !chip_select_n && !write_strobe_n && addr[TEST_SPACE_BIT]; // RULE21
	assign rd = !chip_select_n && !read_strobe_n && addr[TEST_SPACE_BIT]; // RULE21
	assign test_mode = master[MT_PIN_TEST] | master[MT_FACTORY_VEC]; // RULE10

	// Master test control; bits without reset have none, so they start at zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			master <= '0; // RULE3
		end else begin
			if (!hw_reset_n || master_reset) begin
				master[MT_BUS_BY_SEL:MT_PINS_FLOAT] <= '0; // RULE4
			end else if (wr && hit(addr, ADDR_MASTER_TEST)) begin
				master[MT_BUS_BY_SEL:MT_PINS_FLOAT] <= data_in[MT_BUS_BY_SEL:MT_PINS_FLOAT];
			end
			if (chip_select_n) begin
				master[MT_FACTORY_VEC] <= 1'b0; // RULE5
				master[MT_BYPASS] <= 1'b0; // RULE5
				if (!hw_reset_n) begin
					master[MT_ANALOG] <= 1'b0; // RULE5
				end
			end else if (wr && hit(addr, ADDR_MASTER_TEST)) begin
				master[MT_FACTORY_VEC] <= data_in[MT_FACTORY_VEC];
				master[MT_ANALOG] <= data_in[MT_ANALOG];
				master[MT_BYPASS] <= data_in[MT_BYPASS];
			end
		end
	end

	// Forced values in the bus domain; unused bits are never stored
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			forced <= '0;
			force_irq <= 1'b0;
		end else if (!test_mode) begin
			forced <= '0; // RULE22
			force_irq <= 1'b0; // RULE22
		end else if (wr) begin
			if (hit(addr, ADDR_FORCE_RFP)) forced.rx_frame_pulse <= data_in[F_RFP]; // RULE15
			if (hit(addr, ADDR_FORCE_TFP)) forced.tx_frame_pulse <= data_in[F_TFP]; // RULE15
			if (hit(addr, ADDR_FORCE_TCP)) forced.tx_cell_pulse <= data_in[F_TCP]; // RULE15
			if (hit(addr, ADDR_FORCE_GP)) begin
				forced.gen_out <= {data_in[F_GP1], data_in[F_GP0]}; // RULE15
			end
			if (hit(addr, ADDR_FORCE_RX_CELL)) begin
				forced.rx_cell_start <= data_in[F_RX_CELL_START]; // RULE16
				forced.rx_cell_avail <= data_in[F_RCA];
				forced.rx_cell_pulse <= data_in[F_RCP];
				forced.rx_flow_field_out <= data_in[F_RX_FLOW_FIELD_OUT];
				forced.rx_parity_out <= data_in[F_RPAR];
				force_irq <= data_in[F_IRQ];
			end
			if (hit(addr, ADDR_FORCE_RX_BYTE)) forced.rx_byte_out <= data_in; // RULE16
		end
	end

	// Pin clocks are sampled, so edges are found on the system clock
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_fifo_clk_q <= 1'b0;
			internal_byte_clk_q <= 1'b0;
		end else begin
			rx_fifo_clk_q <= pins_in.rx_fifo_clk;
			internal_byte_clk_q <= internal_byte_clk;
		end
	end

	// Marked receive outputs take the forced value only on a FIFO clock rise
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_staged <= '0;
		end else if (!test_mode) begin
			// Stale forced values must not reappear on re-entry
			rx_staged <= '0; // RULE22
		end else if (pins_in.rx_fifo_clk && !rx_fifo_clk_q) begin
			rx_staged.rx_cell_start <= forced.rx_cell_start; // RULE16
			rx_staged.rx_cell_avail <= forced.rx_cell_avail;
			rx_staged.rx_parity_out <= forced.rx_parity_out;
			rx_staged.rx_byte_out <= forced.rx_byte_out;
		end
	end

	// Frame pulse retimed through the byte clock; host waits for it
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rfp_pipe <= '0;
		end else if (!test_mode) begin
			rfp_pipe <= '0; // RULE22
		end else if (internal_byte_clk && !internal_byte_clk_q) begin
			rfp_pipe <= {rfp_pipe[RFP_STAGES-2:0], forced.rx_frame_pulse}; // RULE18
		end
	end

	// Readback of live inputs; unreadable pins have no entry at all
	always_comb begin
		next_rdata = BYTE_ZERO; // RULE14
		if (test_mode) begin
			if (hit(addr, ADDR_RB_TX_DATA)) next_rdata = pins_in.tx_byte_in; // RULE13
			if (hit(addr, ADDR_RB_TX_CTRL)) begin
				next_rdata = {1'b0, pins_in.tx_frame_pulse, pins_in.tx_flow_field_in,
					pins_in.tx_flow_stop, pins_in.tx_cell_start, pins_in.tx_parity_in,
					pins_in.tx_write_en_n, pins_in.tx_fifo_clk}; // RULE13
			end
			if (hit(addr, ADDR_RB_RX_CTRL)) begin
				next_rdata = {pins_in.rx_fifo_clk, pins_in.rx_read_en_n,
					pins_in.tx_serial_enable, 5'h00}; // RULE13
			end
		end
		if (hit(addr, ADDR_MASTER_TEST)) begin
			next_rdata = {1'b0, master}; // RULE1
		end
	end

	// Output mux: normal logic or forced values, then tri-state control
	always_comb begin
		// Line clocks and serial pair are not in the forced set; cell-available is, via D0H
		next_out = normal_out; // RULE20
		if (test_mode) begin
			next_out = forced; // RULE8
			next_out.rx_frame_pulse = rfp_pipe[RFP_STAGES-1];
			next_out.rx_cell_start = rx_staged.rx_cell_start;
			next_out.rx_cell_avail = rx_staged.rx_cell_avail;
			next_out.rx_parity_out = rx_staged.rx_parity_out;
			next_out.rx_byte_out = rx_staged.rx_byte_out;
		end
		next_oe = master[MT_PINS_FLOAT] ? '0 : '1; // RULE6
		// Frame pulse pin stays an input while its direction says so
		if (tx_frame_dir_sel) next_oe.tx_frame_pulse = 1'b0; // RULE19
		if (master[MT_BUS_BY_SEL] && master[MT_PIN_TEST]) begin
			next_data_oe = chip_select_n; // RULE9
		end else if (master[MT_BUS_FLOAT]) begin
			next_data_oe = 1'b0; // RULE7
		end else begin
			next_data_oe = rd;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pins_out <= '0;
			pins_oe <= '0;
			data_out <= BYTE_ZERO;
			data_oe <= 1'b0;
			irq_pin_n_o <= 1'b0;
			irq_pin_n_oe <= 1'b0;
		end else begin
			pins_out <= next_out;
			pins_oe <= next_oe;
			data_out <= next_rdata;
			data_oe <= next_data_oe;
			irq_pin_n_o <= 1'b0;
			// Open drain: only ever drives low
			irq_pin_n_oe <= !master[MT_PINS_FLOAT]
				&& (test_mode ? force_irq : normal_irq); // RULE17
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= '0;
			sub_block_test <= 1'b0;
			clk_units_reset <= 1'b0;
			serial_bypass <= 1'b0;
		end else begin
			mode <= {master[MT_PINS_FLOAT], master[MT_BUS_FLOAT], master[MT_PIN_TEST],
				master[MT_BUS_BY_SEL], master[MT_FACTORY_VEC], master[MT_ANALOG],
				master[MT_BYPASS]};
			sub_block_test <= test_mode; // RULE8
			clk_units_reset <= master[MT_BYPASS]; // RULE11
			serial_bypass <= master[MT_BYPASS]; // RULE11
		end
	end
endmodule

// >>> hw/btm_pkg.sv
// Constants and carrier types for the board test mode control block.
// Assumes one system clock; all pins are sampled on clk_sys.
package btm_pkg;
	localparam logic [7:0] ADDR_MASTER_TEST = 8'h80;
	localparam logic [7:0] ADDR_RB_TX_DATA = 8'h82;
	localparam logic [7:0] ADDR_RB_TX_CTRL = 8'h83;
	localparam logic [7:0] ADDR_RB_RX_CTRL = 8'h84;
	localparam logic [7:0] ADDR_FORCE_RFP = 8'h90;
	localparam logic [7:0] ADDR_FORCE_TFP = 8'h96;
	localparam logic [7:0] ADDR_FORCE_RX_CELL = 8'hD0;
	localparam logic [7:0] ADDR_FORCE_RX_BYTE = 8'hD2;
	localparam logic [7:0] ADDR_FORCE_TCP = 8'hE0;
	localparam logic [7:0] ADDR_FORCE_GP = 8'hEA;
	localparam int TEST_SPACE_BIT = 7;
	// Master test control bit positions
	localparam int MT_PINS_FLOAT = 0;
	localparam int MT_BUS_FLOAT = 1;
	localparam int MT_PIN_TEST = 2;
	localparam int MT_BUS_BY_SEL = 3;
	localparam int MT_FACTORY_VEC = 4;
	localparam int MT_ANALOG = 5;
	localparam int MT_BYPASS = 6;
	// Force register bit positions
	localparam int F_RFP = 2;
	localparam int F_TFP = 0;
	localparam int F_TCP = 1;
	localparam int F_GP1 = 1;
	localparam int F_GP0 = 0;
	localparam int F_RX_CELL_START = 7;
	localparam int F_RCA = 5;
	localparam int F_RCP = 4;
	localparam int F_RX_FLOW_FIELD_OUT = 3;
	localparam int F_RPAR = 1;
	localparam int F_IRQ = 0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Receive frame pulse retimed by this many byte clock edges
	localparam int RFP_STAGES = 2;

	typedef struct packed {
		logic [7:0] tx_byte_in;
		logic tx_frame_pulse;
		logic tx_flow_field_in;
		logic tx_flow_stop;
		logic tx_cell_start;
		logic tx_parity_in;
		logic tx_write_en_n;
		logic tx_fifo_clk;
		logic rx_fifo_clk;
		logic rx_read_en_n;
		logic tx_serial_enable;
	} btm_pins_in_t;

	typedef struct packed {
		logic rx_frame_pulse;
		logic tx_frame_pulse;
		logic tx_cell_pulse;
		logic [1:0] gen_out;
		logic rx_cell_start;
		logic rx_cell_avail;
		logic rx_cell_pulse;
		logic rx_flow_field_out;
		logic rx_parity_out;
		logic [7:0] rx_byte_out;
	} btm_force_t;

	typedef struct packed {
		logic pins_float;
		logic bus_float;
		logic pin_test_enable;
		logic bus_drive_by_select;
		logic factory_vector_test;
		logic analog_factory_test;
		logic bypass;
	} btm_mode_t;
endpackage

// >>> test/btm_test_ctrl_sva.sv
// Port checker for the board test mode control block.
// Assumes single-cycle strobes and one clk_sys domain.
`timescale 1ns/10ps
module btm_test_ctrl_sva (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hw_reset_n,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire btm_pkg::btm_pins_in_t pins_in,
	input wire btm_pkg::btm_force_t pins_oe,
	input wire logic irq_pin_n_oe,
	input wire btm_pkg::btm_mode_t mode,
	input wire logic sub_block_test,
	input wire logic clk_units_reset,
	input wire logic serial_bypass
);
	import btm_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire wr = !chip_select_n && !write_strobe_n && addr[7];
	wire rd = !chip_select_n && !read_strobe_n && addr[7];
	chk_pin_test_set: assert property (wr && addr == 8'h80 && data_in[2] && hw_reset_n
		|-> ##[1:3] sub_block_test) else $error("pin test not entered");
	chk_hw_reset_clr: assert property (!hw_reset_n [*3] |-> mode[6:3] == 4'h0)
		else $error("reset left master bits set");
	chk_sel_clear: assert property (chip_select_n [*3]
		|-> !mode.factory_vector_test && !mode.bypass) else $error("select high kept bits");
	chk_pins_float: assert property (mode.pins_float [*3] |-> pins_oe == '0 && !irq_pin_n_oe)
		else $error("pin driven while floated");
	chk_bus_float: assert property ((mode.bus_float && !mode.bus_drive_by_select) [*3]
		|-> !data_oe) else $error("bus driven while floated");
	chk_bus_by_sel: assert property ((mode.bus_drive_by_select && mode.pin_test_enable
		&& chip_select_n) [*3] |-> data_oe) else $error("bus not driven on select high");
	chk_read_live: assert property (rd && addr == 8'h82 && mode.pin_test_enable
		&& $stable(pins_in.tx_byte_in) |=> ##1 data_out == $past(pins_in.tx_byte_in, 2))
		else $error("readback not live");
	chk_irq_force: assert property (wr && addr == 8'hD0 && data_in[0] && mode.pin_test_enable
		&& !mode.pins_float |-> ##[1:3] irq_pin_n_oe) else $error("irq not pulled");
	chk_bypass_on: assert property (mode.bypass [*2] |-> clk_units_reset && serial_bypass)
		else $error("bypass not applied");
	cover property (wr && addr == 8'hD2);
	cover property (rd && addr == 8'h83);
	cover property (mode.bypass);
endmodule
bind btm_test_ctrl btm_test_ctrl_sva u_sva (.*);

// >>> test/tb_btm_test_ctrl.sv
// Self-checking bench for the board test mode control block.
// Drives every port directly; the host model keeps its own master copy.
`timescale 1ns/10ps
module tb_btm_test_ctrl;
	import btm_pkg::*;
	logic clk_sys = 0, sys_rst = 1, hw_reset_n = 1, master_reset = 0, chip_select_n = 0;
	logic write_strobe_n = 1, read_strobe_n = 1, internal_byte_clk = 0, normal_irq = 0;
	logic tx_frame_dir_sel = 1, data_oe, irq_pin_n_o, irq_pin_n_oe;
	logic sub_block_test, clk_units_reset, serial_bypass;
	logic [7:0] addr = 0, data_in = 0, data_out;
	btm_pins_in_t pins_in = '0;
	btm_force_t normal_out = '0, pins_out, pins_oe;
	btm_mode_t mode;
	logic [31:0] lfsr = 32'hC0A12382, r;
	logic [6:0] m_mode;
	logic [7:0] enter_q[$] = '{8'h91, 8'h95, 8'h99, 8'hA1, 8'hB1, 8'hD1, 8'hE1};
	int fails = 0, cmp_count = 0, cycles = 0;
	btm_test_ctrl u_dut (.*);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// Mode port in master register bit order
	function automatic logic [6:0] mode_bits();
		return {mode.bypass, mode.analog_factory_test, mode.factory_vector_test,
			mode.bus_drive_by_select, mode.pin_test_enable, mode.bus_float, mode.pins_float};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Strobes stay one cycle wide; the block takes them on a single edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		data_in = d;
		write_strobe_n = 0;
		tick(1);
		write_strobe_n = 1;
		if (a == 8'h80)
			m_mode = d[6:0];
		tick(3);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		read_strobe_n = 0;
		tick(1);
		check(data_oe, 1);
		read_strobe_n = 1;
		tick(1);
		check(data_out, exp);
	endtask
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		tick(16);
		sys_rst = 0;
		tick(2);
		check(mode_bits(), 0);
		// Frame pulse pin starts as an input, so its enable stays low
		check(pins_oe, 18'h2FFFF);
		normal_out.gen_out = 2'b10;
		repeat (4) begin
			r = rnd();
			wr(8'h80, {1'b0, r[6:0]});
			check(mode_bits(), m_mode);
		end
		wr(8'h80, 8'h04);
		rd(8'h80, 8'h04);
		wr(8'h10, 8'h07);
		check(mode_bits(), m_mode);
		foreach (enter_q[i]) wr(enter_q[i], 8'h00);
		repeat (4) begin
			r = rnd();
			pins_in = r[17:0];
			rd(8'h82, r[17:10]);
			rd(8'h83, {1'b0, r[9:3]});
			rd(8'h84, {r[2:0], 5'h00});
		end
		rd(8'hFF, 8'h00);
		pins_in = '0;
		tx_frame_dir_sel = 0;
		wr(8'hEA, 8'h03);
		wr(8'h96, 8'h01);
		wr(8'hE0, 8'h02);
		wr(8'hD0, 8'h01);
		check({pins_out.gen_out, pins_out.tx_frame_pulse, pins_out.tx_cell_pulse}, 4'hF);
		check({irq_pin_n_oe, irq_pin_n_o}, 2'b10);
		wr(8'hD2, 8'hA5);
		wr(8'hD0, 8'hBA);
		check(irq_pin_n_oe, 0);
		check(pins_out.rx_byte_out, 8'h00);
		pins_in.rx_fifo_clk = 1;
		tick(4);
		check(pins_out.rx_byte_out, 8'hA5);
		check(pins_out[12:8], 5'h1F);
		wr(8'h90, 8'h04);
		repeat (2) begin
			internal_byte_clk = 1;
			tick(2);
			internal_byte_clk = 0;
			tick(2);
		end
		check(pins_out.rx_frame_pulse, 1);
		wr(8'h80, 8'h05);
		check({pins_oe, irq_pin_n_oe}, 0);
		wr(8'h80, 8'h06);
		addr = 8'h82;
		read_strobe_n = 0;
		tick(1);
		check(data_oe, 0);
		read_strobe_n = 1;
		tick(1);
		check(data_out, 8'h00);
		wr(8'h80, 8'h0E);
		chip_select_n = 1;
		tick(3);
		check(data_oe, 1);
		chip_select_n = 0;
		tick(3);
		check(data_oe, 0);
		wr(8'h80, 8'h50);
		check({sub_block_test, clk_units_reset, serial_bypass}, 3'b111);
		chip_select_n = 1;
		tick(3);
		check(mode_bits(), 0);
		chip_select_n = 0;
		wr(8'h80, 8'h2C);
		hw_reset_n = 0;
		tick(3);
		check(mode_bits(), 7'h20);
		chip_select_n = 1;
		tick(3);
		check(mode_bits(), 0);
		hw_reset_n = 1;
		chip_select_n = 0;
		wr(8'h80, 8'h0D);
		master_reset = 1;
		tick(1);
		master_reset = 0;
		tick(3);
		check(mode_bits(), 0);
		check(pins_out.gen_out, 2'b10);
		conclude();
	end
endmodule
